// [verilog/rsvm_pkg.sv]
// constants shared by the reset source and voltage monitor block
// Contract
// - internal reset asserted while the external reset pin is low
// - power-on reset held until supply good, then a fixed release delay
// - each of three monitor channels can raise its own reset cause
// - deep standby wake-up raises a distinct reset cause
// - independent watchdog underflow or refresh error raises its reset
// - main watchdog underflow or refresh error raises a separate reset
// - writing the key value to a control register requests a software reset
// - channel 0 reset enabled by option memory; threshold from two levels
// - channels 1 and 2 threshold chosen from five levels
// - channels 1 and 2 digital filter sampled at clock divided by 2,4,8,16
// - two selectable release policies for channel 1 and 2 monitor resets
// - channels 1 and 2 each detect supply rising above or falling below threshold
// - monitor interrupt selectable as maskable or non-maskable
// - comparison state readable; detection event sent to event fabric
package rsvm_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int RELEASE_TIME_US = 1000;
  localparam int RELEASE_CYCLES = RELEASE_TIME_US * CLK_MHZ;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CAUSE = 8'h00;
  localparam logic [7:0] OFS_SWRST = 8'h04;
  localparam logic [7:0] OFS_VD0 = 8'h08;
  localparam logic [7:0] OFS_VD1 = 8'h0c;
  localparam logic [7:0] OFS_VD2 = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_INT_STAT = 8'h18;
  localparam logic [7:0] OFS_INT_MASK = 8'h1c;
  localparam logic [15:0] SW_KEY = 16'ha501;
  // ----------------------------------------------------------------
  // reset cause bits
  // ----------------------------------------------------------------
  localparam int NUM_CAUSES = 9;
  localparam int C_PIN = 0;
  localparam int C_POR = 1;
  localparam int C_VD0 = 2;
  localparam int C_VD1 = 3;
  localparam int C_VD2 = 4;
  localparam int C_DSTBY = 5;
  localparam int C_INDEPENDENT_WATCHDOG = 6;
  localparam int C_WDT = 7;
  localparam int C_SW = 8;
  localparam logic [8:0] CAUSE_RESET = 9'h002;
  // ----------------------------------------------------------------
  // channel 1/2 control layout
  // ----------------------------------------------------------------
  localparam int F_LEVEL = 0;
  localparam int F_FILT_EN = 3;
  localparam int F_DIV = 4;
  localparam int F_RST_EN = 6;
  localparam int F_REL_POL = 7;
  localparam int F_EDGE_RISE = 8;
  localparam int F_NMI_SEL = 9;
  localparam int F_INT_EN = 10;
  localparam int VD_CTRL_W = 11;
  localparam logic [10:0] VD_CTRL_RESET = 11'h000;
  localparam logic [2:0] MAX_LEVEL = 3'h4;
  localparam logic VD0_LEVEL_RESET = 1'b0;
  localparam logic [1:0] INT_STAT_RESET = 2'h0;
  localparam logic [1:0] INT_MASK_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [verilog/rsvm_filter.sv]
// digital noise filter for one comparator output
`timescale 1ns/1ps
`default_nettype none
module rsvm_filter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sample,
  input wire logic enable,
  input wire logic din,
  output logic dout
);
  logic last;

  // ----------------------------------------------------------------
  // two matching samples move the output
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last <= 1'b0;
      dout <= 1'b0;
    end else if (!enable) begin
      last <= din;
      dout <= din;
    end else if (sample) begin
      last <= din;
      // a single glitching sample never reaches the output
      if (last == din) begin
        dout <= din;
      end
    end
  end

  bypass_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !enable |=> dout == $past(din))
    else $error("filter bypass does not follow input");

  filter_agree_a: assert property (@(posedge aclk) disable iff (!aresetn)
    enable && $past(enable) && $changed(dout) |-> $past(sample) && $past(last) == dout)
    else $error("filtered output moved without two matching samples");
endmodule
`default_nettype wire

// [verilog/rsvm_top.sv]
// reset source collector and supply voltage monitor control
`timescale 1ns/1ps
`default_nettype none
module rsvm_top
  import rsvm_pkg::*;
#(
  parameter int RELEASE_CNT = RELEASE_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // reset sources
  input wire logic ext_reset_pin_n,
  input wire logic vcc_por_ok,
  input wire logic vd0_reset_en,
  input wire logic deep_standby_wake,
  input wire logic independent_watchdog_underflow,
  input wire logic independent_watchdog_refresh_err,
  input wire logic wdt_underflow,
  input wire logic wdt_refresh_err,
  // supply_voltage_detector comparators, high while vcc below level
  input wire logic vd0_below,
  input wire logic vd1_below,
  input wire logic vd2_below,
  output logic vd0_level,
  output logic [2:0] vd1_level,
  output logic [2:0] vd2_level,
  output logic vd1_event,
  output logic vd2_event,
  output logic irq,
  output logic nmi,
  output logic internal_reset_n
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] clamp_level(logic [2:0] v);
    return (v > MAX_LEVEL) ? MAX_LEVEL : v;
  endfunction

  function automatic logic [VD_CTRL_W-1:0] ctrl_write(logic [VD_CTRL_W-1:0] old,
                                                     logic [31:0] nw, logic [3:0] strb);
    logic [31:0] m;
    logic [VD_CTRL_W-1:0] r;
    m = merge({21'h0, old}, nw, strb);
    r = m[VD_CTRL_W-1:0];
    r[F_LEVEL +: 3] = clamp_level(m[F_LEVEL +: 3]);
    return r;
  endfunction

  function automatic logic div_tick(logic [3:0] cnt, logic [1:0] sel);
    logic t;
    unique case (sel)
      2'h0: t = cnt[0];
      2'h1: t = &cnt[1:0];
      2'h2: t = &cnt[2:0];
      2'h3: t = &cnt[3:0];
    endcase
    return t;
  endfunction

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [NUM_CAUSES-1:0] cause;
  logic [1:0][VD_CTRL_W-1:0] vd_ctrl;
  logic [1:0] int_stat;
  logic [1:0] int_mask;
  logic sw_req;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic wr_hit;
  logic [31:0] w1c;
  logic [31:0] rd_data;
  logic rd_hit;

  // ----------------------------------------------------------------
  // axi4-lite write channels
  // ----------------------------------------------------------------
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign w1c = merge(32'h0, w_data, w_strb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awready && s_axi_awvalid) begin
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_comb begin
    unique case ({aw_addr[7:2], 2'h0})
      OFS_CAUSE, OFS_SWRST, OFS_VD0, OFS_VD1, OFS_VD2, OFS_STATUS, OFS_INT_STAT, OFS_INT_MASK:
        wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vd0_level <= VD0_LEVEL_RESET;
      vd_ctrl <= {VD_CTRL_RESET, VD_CTRL_RESET};
      int_mask <= INT_MASK_RESET;
    end else if (do_write) begin
      if ({aw_addr[7:2], 2'h0} == OFS_VD0 && w_strb[0]) begin
        vd0_level <= w_data[0];
      end
      if ({aw_addr[7:2], 2'h0} == OFS_VD1) begin
        vd_ctrl[0] <= ctrl_write(vd_ctrl[0], w_data, w_strb);
      end
      if ({aw_addr[7:2], 2'h0} == OFS_VD2) begin
        vd_ctrl[1] <= ctrl_write(vd_ctrl[1], w_data, w_strb);
      end
      if ({aw_addr[7:2], 2'h0} == OFS_INT_MASK && w_strb[0]) begin
        int_mask <= w_data[1:0];
      end
    end
  end

  // both low bytes must carry the key, so a stray byte write cannot reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_req <= 1'b0;
    end else begin
      sw_req <= do_write && {aw_addr[7:2], 2'h0} == OFS_SWRST
                && (&w_strb[1:0]) && w_data[15:0] == SW_KEY;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vd1_level <= 3'h0;
      vd2_level <= 3'h0;
    end else begin
      vd1_level <= vd_ctrl[0][F_LEVEL +: 3];
      vd2_level <= vd_ctrl[1][F_LEVEL +: 3];
    end
  end

  // ----------------------------------------------------------------
  // filtering and edge detection, channels 1 and 2
  // ----------------------------------------------------------------
  logic [3:0] presc;
  logic [1:0] below_raw;
  logic [1:0] below_f;
  logic [1:0] below_q;
  logic [1:0] fell_below;
  logic [1:0] rose_above;
  logic [1:0] det;
  logic [1:0] ch_src;

  assign below_raw = {vd2_below, vd1_below};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc <= 4'h0;
    end else begin
      presc <= presc + 4'h1;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_ch
    rsvm_filter u_filt (
      .aclk(aclk),
      .aresetn(aresetn),
      .sample(div_tick(presc, vd_ctrl[g][F_DIV +: 2])),
      .enable(vd_ctrl[g][F_FILT_EN]),
      .din(below_raw[g]),
      .dout(below_f[g])
    );
    assign fell_below[g] = below_f[g] && !below_q[g];
    assign rose_above[g] = !below_f[g] && below_q[g];
    assign det[g] = vd_ctrl[g][F_EDGE_RISE] ? rose_above[g] : fell_below[g];
    // policy 0 holds until supply recovers, policy 1 only starts the delay
    assign ch_src[g] = vd_ctrl[g][F_RST_EN]
                       && (vd_ctrl[g][F_REL_POL] ? fell_below[g] : below_f[g]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      below_q <= 2'h0;
      vd1_event <= 1'b0;
      vd2_event <= 1'b0;
    end else begin
      below_q <= below_f;
      vd1_event <= det[0];
      vd2_event <= det[1];
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, mask and outputs
  // ----------------------------------------------------------------
  logic [1:0] nmi_sel;

  assign nmi_sel = {vd_ctrl[1][F_NMI_SEL], vd_ctrl[0][F_NMI_SEL]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_stat <= INT_STAT_RESET;
    end else begin
      // a detection in the clearing cycle survives the clear
      int_stat <= (int_stat & ~((do_write && {aw_addr[7:2], 2'h0} == OFS_INT_STAT)
                  ? w1c[1:0] : 2'h0))
                  | (det & {vd_ctrl[1][F_INT_EN], vd_ctrl[0][F_INT_EN]});
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
      nmi <= 1'b0;
    end else begin
      // a set mask bit blocks irq only; nmi routing ignores the mask
      irq <= |(int_stat & ~int_mask & ~nmi_sel);
      nmi <= |(int_stat & nmi_sel);
    end
  end

  // ----------------------------------------------------------------
  // reset sources and release delay
  // ----------------------------------------------------------------
  logic [NUM_CAUSES-1:0] src;
  logic any_src;
  logic [31:0] rel_cnt;

  always_comb begin
    src = '0;
    src[C_PIN] = !ext_reset_pin_n;
    src[C_POR] = !vcc_por_ok;
    src[C_VD0] = vd0_below && vd0_reset_en;
    src[C_VD1] = ch_src[0];
    src[C_VD2] = ch_src[1];
    src[C_DSTBY] = deep_standby_wake;
    src[C_INDEPENDENT_WATCHDOG] = independent_watchdog_underflow || independent_watchdog_refresh_err;
    src[C_WDT] = wdt_underflow || wdt_refresh_err;
    src[C_SW] = sw_req;
  end

  assign any_src = |src;

  // the delay restarts on every active cycle, so it runs from the last one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rel_cnt <= 32'(RELEASE_CNT);
      internal_reset_n <= 1'b0;
    end else if (any_src) begin
      rel_cnt <= 32'(RELEASE_CNT);
      internal_reset_n <= 1'b0;
    end else if (rel_cnt != 32'h0) begin
      rel_cnt <= rel_cnt - 32'h1;
      internal_reset_n <= 1'b0;
    end else begin
      internal_reset_n <= 1'b1;
    end
  end

  // a new reset from the released state replaces the old record
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause <= CAUSE_RESET;
    end else if (any_src && internal_reset_n) begin
      cause <= src;
    end else begin
      cause <= (cause & ~((do_write && {aw_addr[7:2], 2'h0} == OFS_CAUSE)
               ? w1c[NUM_CAUSES-1:0] : '0)) | src;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = 32'h0;
    rd_hit = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'h0})
      OFS_CAUSE: rd_data[NUM_CAUSES-1:0] = cause;
      OFS_SWRST: rd_data = 32'h0;
      OFS_VD0: rd_data[0] = vd0_level;
      OFS_VD1: rd_data[VD_CTRL_W-1:0] = vd_ctrl[0];
      OFS_VD2: rd_data[VD_CTRL_W-1:0] = vd_ctrl[1];
      OFS_STATUS: rd_data[2:0] = {below_f, vd0_below};
      OFS_INT_STAT: rd_data[1:0] = int_stat;
      OFS_INT_MASK: rd_data[1:0] = int_mask;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence reset_taken_s(int c);
    !internal_reset_n && cause[c];
  endsequence

  sequence released_s;
    $rose(internal_reset_n);
  endsequence

  pin_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ext_reset_pin_n |=> reset_taken_s(C_PIN))
    else $error("pin low did not assert internal reset");

  por_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
    released_s |-> $past(rel_cnt) == 32'h0 && $past(vcc_por_ok) && $past(!any_src))
    else $error("reset released before delay or supply good");

  vd_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ch_src[0] |=> reset_taken_s(C_VD1))
    else $error("monitor reset not recorded");

  dstby_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
    deep_standby_wake |=> reset_taken_s(C_DSTBY))
    else $error("deep standby reset not recorded");

  independent_watchdog_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
    independent_watchdog_underflow || independent_watchdog_refresh_err |=> reset_taken_s(C_INDEPENDENT_WATCHDOG))
    else $error("independent watchdog reset missing");

  wdt_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wdt_underflow || wdt_refresh_err) && !independent_watchdog_underflow |=> reset_taken_s(C_WDT)
    ##0 (!cause[C_INDEPENDENT_WATCHDOG] || $past(internal_reset_n) == 1'b0
    || $past(independent_watchdog_refresh_err)))
    else $error("watchdog reset missing");

  sw_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && {aw_addr[7:2], 2'h0} == OFS_SWRST && (&w_strb[1:0])
    && w_data[15:0] == SW_KEY |=> ##1 reset_taken_s(C_SW))
    else $error("software reset key ignored");

  vd0_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    internal_reset_n && vd0_below && !vd0_reset_en && !(|(src & ~(9'h1 << C_VD0)))
    |=> internal_reset_n && !$rose(cause[C_VD0]))
    else $error("disabled channel 0 caused a reset");

  level_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
    vd1_level <= MAX_LEVEL && vd2_level <= MAX_LEVEL)
    else $error("threshold level out of range");

  policy_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    vd_ctrl[1][F_RST_EN] && vd_ctrl[1][F_REL_POL] && below_f[1] && below_q[1] |-> !ch_src[1])
    else $error("pulse policy held the reset source");

  edge_event_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !vd_ctrl[0][F_EDGE_RISE] && fell_below[0] |=> vd1_event)
    else $error("falling supply detection lost");

  irq_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (int_stat & ~int_mask & ~nmi_sel) != 2'h0 |=> irq ##0 (nmi == $past(|(int_stat & nmi_sel))))
    else $error("interrupt routing wrong");

  event_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
    vd1_event |-> $past(det[0]))
    else $error("event output without detection");

  hold_any_a: assert property (@(posedge aclk) disable iff (!aresetn)
    any_src |=> !internal_reset_n [*2])
    else $error("reset not held after source");
endmodule
`default_nettype wire

// [verif/rsvm_far_model.sv]
// far-side model: reset pin, supply comparators and watchdog event lines
`timescale 1ns/1ps
`default_nettype none
module rsvm_far_model (
  input wire logic aclk,
  output logic pin_n,
  output logic por_ok,
  output logic [4:0] evt,
  output logic [2:0] below
);
  // supply ramps for a while after power is applied
  initial begin
    pin_n = 1'b1;
    por_ok = 1'b0;
    evt = 5'h00;
    below = 3'h0;
    repeat (12) @(posedge aclk);
    por_ok <= 1'b1;
  end
  // wake and watchdog events are single-cycle pulses
  task automatic pulse(input int k);
    @(posedge aclk);
    evt[k] <= 1'b1;
    @(posedge aclk);
    evt <= 5'h00;
  endtask
  // comparators are slow, so a level stays until changed
  task automatic supply(input int ch, input logic lo);
    @(posedge aclk);
    below[ch] <= lo;
  endtask
  task automatic pin(input logic v);
    @(posedge aclk);
    pin_n <= v;
  endtask
endmodule
`default_nettype wire

// [verif/tb_rsvm_top.sv]
// self-checking bench for the reset source and voltage monitor block
`timescale 1ns/1ps
`default_nettype none
module tb_rsvm_top;
  import rsvm_pkg::*;
  localparam int REL = 8;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, opt_en;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rd;
  logic [3:0] wstrb, ws;
  logic [1:0] rs;
  wire logic awready, wready, bvalid, arready, rvalid, pin_n, por_ok, rst_n;
  wire logic vd0_level, vd1_event, vd2_event, irq, nmi;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [4:0] evt;
  wire logic [2:0] below, vd1_level, vd2_level;
  int num_errors = 0;
  int check_count = 0;
  int ev1 = 0;
  int ev2 = 0;
  int e;
  int cmap[5] = '{C_DSTBY, C_INDEPENDENT_WATCHDOG, C_INDEPENDENT_WATCHDOG, C_WDT, C_WDT};
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  rsvm_far_model rsvm_far_model_i (.aclk(aclk), .pin_n(pin_n), .por_ok(por_ok), .evt(evt),
    .below(below));
  rsvm_top #(.RELEASE_CNT(REL)) rsvm_top_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_reset_pin_n(pin_n), .vcc_por_ok(por_ok), .vd0_reset_en(opt_en),
    .deep_standby_wake(evt[0]), .independent_watchdog_underflow(evt[1]), .independent_watchdog_refresh_err(evt[2]),
    .wdt_underflow(evt[3]), .wdt_refresh_err(evt[4]), .vd0_below(below[0]),
    .vd1_below(below[1]), .vd2_below(below[2]), .vd0_level(vd0_level),
    .vd1_level(vd1_level), .vd2_level(vd2_level), .vd1_event(vd1_event),
    .vd2_event(vd2_event), .irq(irq), .nmi(nmi), .internal_reset_n(rst_n));
  always @(posedge aclk) begin
    if (vd1_event === 1'b1) ev1 <= ev1 + 1;
    if (vd2_event === 1'b1) ev2 <= ev2 + 1;
  end
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_on, w_on;
    aw_on = 1'b1;
    w_on = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= ws;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_on || w_on) begin
      @(posedge aclk);
      if (aw_on && awready === 1'b1) begin
        aw_on = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_on && wready === 1'b1) begin
        w_on = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
    // register effects reach the registered outputs one edge later
    @(posedge aclk);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_rst(input logic lvl, input int lim);
    int n;
    n = 0;
    while (rst_n !== lvl && n < lim) begin
      @(posedge aclk);
      n++;
    end
    chk(32'(rst_n), 32'(lvl));
  endtask
  // reset must assert, release after the delay, and name its cause
  task automatic released(input int b);
    wait_rst(1'b0, 6);
    wait_rst(1'b1, REL + 30);
    rd_reg(OFS_CAUSE);
    chk(rd, 32'h1 << b);
  endtask
  task automatic complete_run;
    if (num_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    complete_run;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb, ws} = {8'h00, 8'h00, 32'h0, 4'h0, 4'hf};
    {awvalid, wvalid, bready, arvalid, rready, opt_en} = 6'h01;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    chk(32'(rst_n), 32'h0);
    released(C_POR);
    wr(OFS_CAUSE, 32'h1ff);
    rd_reg(OFS_CAUSE);
    chk(rd, 32'h0);
    rd_reg(OFS_VD1);
    chk(rd, 32'h0);
    rd_reg(OFS_INT_MASK);
    chk(rd, 32'h0);
    wr(8'h20, 32'h1);
    chk(32'(rs), 32'(RESP_SLVERR));
    rd_reg(8'h20);
    chk({rd[29:0], rs}, {30'h0, RESP_SLVERR});
    wr(OFS_VD1, 32'h7);
    chk(32'(vd1_level), 32'h4);
    wr(OFS_VD1, 32'h2);
    chk(32'(vd1_level), 32'h2);
    wr(OFS_VD0, 32'h1);
    chk(32'(vd0_level), 32'h1);
    rsvm_far_model_i.pin(1'b0);
    repeat (20) @(posedge aclk);
    chk(32'(rst_n), 32'h0);
    rsvm_far_model_i.pin(1'b1);
    released(C_PIN);
    for (int k = 0; k < 5; k++) begin
      rsvm_far_model_i.pulse(k);
      released(cmap[k]);
    end
    rsvm_far_model_i.supply(0, 1'b1);
    wait_rst(1'b0, 6);
    rsvm_far_model_i.supply(0, 1'b0);
    released(C_VD0);
    wr(OFS_VD1, 32'h1 << F_RST_EN);
    rsvm_far_model_i.supply(1, 1'b1);
    repeat (REL + 20) @(posedge aclk);
    chk(32'(rst_n), 32'h0);
    rsvm_far_model_i.supply(1, 1'b0);
    released(C_VD1);
    wr(OFS_VD1, 32'h0);
    wr(OFS_VD2, (32'h1 << F_RST_EN) | (32'h1 << F_REL_POL));
    rsvm_far_model_i.supply(2, 1'b1);
    released(C_VD2);
    rsvm_far_model_i.supply(2, 1'b0);
    wr(OFS_VD2, 32'h0);
    ws = 4'h1;
    wr(OFS_SWRST, 32'ha501);
    ws = 4'hf;
    wr(OFS_SWRST, 32'ha500);
    repeat (6) @(posedge aclk);
    chk(32'(rst_n), 32'h1);
    wr(OFS_SWRST, 32'ha501);
    released(C_SW);
    opt_en <= 1'b0;
    rsvm_far_model_i.supply(0, 1'b1);
    repeat (10) @(posedge aclk);
    chk(32'(rst_n), 32'h1);
    rsvm_far_model_i.supply(0, 1'b0);
    e = ev1;
    wr(OFS_VD1, 32'h1 << F_INT_EN);
    rsvm_far_model_i.supply(1, 1'b1);
    repeat (4) @(posedge aclk);
    chk({irq, 31'(ev1 - e)}, {1'b1, 31'h1});
    rd_reg(OFS_STATUS);
    chk(rd, 32'h2);
    rd_reg(OFS_INT_STAT);
    chk(rd, 32'h1);
    wr(OFS_INT_MASK, 32'h1);
    chk(32'(irq), 32'h0);
    wr(OFS_INT_MASK, 32'h0);
    chk(32'(irq), 32'h1);
    wr(OFS_INT_STAT, 32'h1);
    chk(32'(irq), 32'h0);
    wr(OFS_VD1, (32'h1 << F_INT_EN) | (32'h1 << F_EDGE_RISE));
    rsvm_far_model_i.supply(1, 1'b0);
    repeat (4) @(posedge aclk);
    chk({irq, 31'(ev1 - e)}, {1'b1, 31'h2});
    wr(OFS_INT_STAT, 32'h1);
    wr(OFS_VD2, (32'h1 << F_INT_EN) | (32'h1 << F_NMI_SEL) | 32'h3);
    chk(32'(vd2_level), 32'h3);
    wr(OFS_INT_MASK, 32'h3);
    e = ev2;
    rsvm_far_model_i.supply(2, 1'b1);
    repeat (4) @(posedge aclk);
    chk({nmi, irq, 30'(ev2 - e)}, {2'h2, 30'h1});
    wr(OFS_INT_STAT, 32'h2);
    chk(32'(nmi), 32'h0);
    rsvm_far_model_i.supply(2, 1'b0);
    wr(OFS_VD2, (32'h1 << F_FILT_EN) | (32'h3 << F_DIV));
    repeat (40) @(posedge aclk);
    rsvm_far_model_i.supply(2, 1'b1);
    repeat (7) @(posedge aclk);
    rsvm_far_model_i.supply(2, 1'b0);
    repeat (40) @(posedge aclk);
    rd_reg(OFS_STATUS);
    chk(rd, 32'h0);
    for (int d = 0; d < 4; d++) begin
      wr(OFS_VD2, (32'h1 << F_FILT_EN) | (32'(d) << F_DIV));
      rsvm_far_model_i.supply(2, 1'b1);
      rd_reg(OFS_STATUS);
      chk(rd, 32'h0);
      repeat ((2 << d) * 3 + 4) @(posedge aclk);
      rd_reg(OFS_STATUS);
      chk(rd, 32'h4);
      rsvm_far_model_i.supply(2, 1'b0);
      repeat ((2 << d) * 3 + 4) @(posedge aclk);
    end
    complete_run;
  end
endmodule
`default_nettype wire
